// ==== rtl/emc_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// - bit 0 enables the partition B wait-state generator
// - bit 1 enables the partition A wait-state generator
// - bits 3:2 give B one, two, three, or ready-extended wait states
// - bits 5:4 give A the same wait-state choices
// - each wait state lasts exactly one input clock period
// - bit 6 makes low flag nibble outputs unless wide port selected
// - bit 7 makes high flag nibble outputs unless wide port selected
// - bit 8 low: dual pin is memory output enable
// - bit 8 high: dual pin signals a pending external access
// - in that mode the pin is NOT of (bit 9 OR pending)
// - bit 9 does nothing while bit 8 is low
// - 22-bit address bus is a three-state output
// - data bus three-state: driven on writes, memory drives reads
// - data bus is 32 bits wide
// - pending-no-grant goes low while waiting without bus ownership
// - four active-low byte lane selects pick bytes of the word
module emc_ctrl (
  input wire logic REF_CLK, // clock
  input wire logic RESET_N, // async reset, active low
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // bus address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write when high
  input wire logic [2:0] HSIZE, // transfer size, words only
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic HREADYOUT, // slave ready
  output logic [31:0] HRDATA, // read data
  output logic HRESP, // always okay
  input wire logic BUS_GRANT, // external bus granted to us
  input wire logic EXT_READY_LOW, // memory ready, active low
  output emc_pkg::emc_addr_type ADDRESS_BUS_PINS_O, // address out
  output logic ADDRESS_BUS_PINS_OE, // address drive enable
  input wire emc_pkg::emc_data_type DATA_BUS_PINS_I, // data in
  output emc_pkg::emc_data_type DATA_BUS_PINS_O, // data out
  output logic DATA_BUS_PINS_OE, // data drive enable
  output emc_pkg::emc_lane_type BYTE_LANE_SELECT_N_O, // lanes, low
  output logic BYTE_LANE_SELECT_N_OE, // lane drive enable
  output logic DUAL_PIN_O, // output enable or pending, low
  output logic DUAL_PIN_OE, // dual pin drive enable
  output logic PENDING_NO_GRANT_N, // waiting without bus, low
  input wire emc_pkg::emc_flag_type HOST_PORT_FLAG_PINS_I, // flags in
  output emc_pkg::emc_flag_type HOST_PORT_FLAG_PINS_O, // flags out
  output emc_pkg::emc_flag_type HOST_PORT_FLAG_PINS_OE // flag enables
);
  import emc_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ACCESS_WAITING_FORCE, S_ACC, S_HOLD} emc_state_type;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic grant_s;
  logic ready_low_s;
  emc_flag_type flag_in_s;
  emc_data_type data_in_s;

  emc_sync #(.W(2 + FLAG_W + DATA_W)) u_sync (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .d({BUS_GRANT, EXT_READY_LOW, HOST_PORT_FLAG_PINS_I, DATA_BUS_PINS_I}),
    .q({grant_s, ready_low_s, flag_in_s, data_in_s})
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic ahb_go;
  logic wr_access_waiting_force_q;
  logic rd_access_waiting_force_q;
  logic [7:0] bus_addr_q;
  logic hready_q;
  emc_data_type hrdata_q;

  assign ahb_go = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_access_waiting_force_q <= 1'b0;
      rd_access_waiting_force_q <= 1'b0;
      bus_addr_q <= 8'h00;
    end else begin
      wr_access_waiting_force_q <= ahb_go && HWRITE;
      rd_access_waiting_force_q <= ahb_go && !HWRITE;
      if (ahb_go) begin
        bus_addr_q <= {HADDR[7:2], 2'b00};
      end
    end
  end

  // reads take one wait cycle so that a write just before is visible
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hready_q <= 1'b1;
    end else begin
      hready_q <= !(ahb_go && !HWRITE);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  emc_cw_type ctrl_q;
  logic wide_q;
  emc_flag_type flag_out_q;
  emc_addr_type acc_addr_q;
  emc_data_type acc_wdata_q;
  logic acc_wr_q;
  emc_lane_type acc_lanes_q;
  emc_data_type acc_rdata_q;
  emc_state_type state_q;
  emc_state_type state_d;
  logic start_req;
  logic wr_hit;

  assign wr_hit = wr_access_waiting_force_q;
  assign start_req = wr_hit && bus_addr_q == OFS_ACC_CMD &&
                     HWDATA[CMD_START] && state_q == S_IDLE;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= CTRL_WORD_RST;
    end else if (wr_hit && bus_addr_q == OFS_CTRL_WORD) begin
      ctrl_q <= HWDATA[CW_W-1:0] & CW_USED_MASK;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wide_q <= PORT_CTRL_RST;
      flag_out_q <= FLAG_OUT_RST;
    end else if (wr_hit) begin
      if (bus_addr_q == OFS_PORT_CTRL) begin
        wide_q <= HWDATA[BIT_WIDE_PORT];
      end
      if (bus_addr_q == OFS_FLAG_OUT) begin
        flag_out_q <= HWDATA[FLAG_W-1:0];
      end
    end
  end

  // access set-up is frozen while an access runs
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_addr_q <= '0;
      acc_wdata_q <= '0;
      acc_wr_q <= 1'b0;
      acc_lanes_q <= '0;
    end else if (wr_hit && state_q == S_IDLE) begin
      if (bus_addr_q == OFS_ACC_ADDR) begin
        acc_addr_q <= HWDATA[ADDR_W-1:0];
      end
      if (bus_addr_q == OFS_ACC_WDATA) begin
        acc_wdata_q <= HWDATA;
      end
      if (start_req) begin
        acc_wr_q <= HWDATA[CMD_WRITE];
        acc_lanes_q <= HWDATA[CMD_LANES +: LANE_W];
      end
    end
  end

  function automatic emc_data_type read_mux(input logic [7:0] a);
    emc_data_type r;
    r = '0;
    unique case (a)
      OFS_CTRL_WORD: r[CW_W-1:0] = ctrl_q;
      OFS_PORT_CTRL: r[BIT_WIDE_PORT] = wide_q;
      OFS_FLAG_OUT: r[FLAG_W-1:0] = flag_out_q;
      OFS_FLAG_IN: r[FLAG_W-1:0] = flag_in_s;
      OFS_ACC_ADDR: r[ADDR_W-1:0] = acc_addr_q;
      OFS_ACC_WDATA: r = acc_wdata_q;
      OFS_ACC_CMD: begin
        r[STAT_BUSY] = state_q != S_IDLE;
        r[STAT_ACCESS_WAITING_FORCE] = state_q == S_ACCESS_WAITING_FORCE;
      end
      OFS_ACC_RDATA: r = acc_rdata_q;
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hrdata_q <= '0;
    end else if (rd_access_waiting_force_q) begin
      hrdata_q <= read_mux(bus_addr_q);
    end
  end

  assign HREADYOUT = hready_q;
  assign HRDATA = hrdata_q;
  assign HRESP = 1'b0;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  emc_wait_if wif ();
  logic part_b;
  logic [1:0] hold_q;

  emc_waitgen u_waitgen (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .ready_low_s(ready_low_s),
    .w(wif.gen)
  );

  assign part_b = acc_addr_q[PART_B_BIT];
  assign wif.start = state_q == S_ACCESS_WAITING_FORCE && grant_s;
  assign wif.enable = part_b ? ctrl_q[BIT_B_EN] : ctrl_q[BIT_A_EN];
  assign wif.code = part_b ? ctrl_q[FLD_B_CNT +: 2] :
                             ctrl_q[FLD_A_CNT +: 2];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (start_req) state_d = S_ACCESS_WAITING_FORCE;
      S_ACCESS_WAITING_FORCE: if (grant_s) state_d = S_ACC;
      S_ACC: if (wif.done) state_d = S_HOLD;
      S_HOLD: if (hold_q == 2'h0) state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // strobe stays on until the bus has crossed the pin register and the
  // synchroniser; one cycle less samples a stale bus with no wait states
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_q <= 2'h0;
    end else if (state_q == S_ACC) begin
      hold_q <= 2'(SYNC_STAGES);
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_rdata_q <= '0;
    end else if (state_q == S_HOLD && hold_q == 2'h0 && !acc_wr_q) begin
      acc_rdata_q <= data_in_s;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic in_acc;
  logic pending;
  logic strobe;
  emc_addr_type addr_o_q;
  logic addr_oe_q;
  emc_data_type data_o_q;
  logic data_oe_q;
  emc_lane_type lane_n_q;
  logic lane_oe_q;
  logic dual_q;
  logic access_waiting_force_n_q;
  emc_flag_type flag_o_q;
  emc_flag_type flag_oe_q;

  assign in_acc = state_q == S_ACC || state_q == S_HOLD;
  assign pending = state_q == S_ACCESS_WAITING_FORCE;
  assign strobe = in_acc && !acc_wr_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_o_q <= '0;
      addr_oe_q <= 1'b0;
      data_o_q <= '0;
      data_oe_q <= 1'b0;
      lane_n_q <= '1;
      lane_oe_q <= 1'b0;
    end else begin
      addr_o_q <= acc_addr_q;
      addr_oe_q <= in_acc;
      data_o_q <= acc_wdata_q;
      data_oe_q <= in_acc && acc_wr_q;
      lane_n_q <= in_acc ? ~acc_lanes_q : '1;
      lane_oe_q <= in_acc;
    end
  end

  // pending output and the dual pin are always driven
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dual_q <= 1'b1;
      access_waiting_force_n_q <= 1'b1;
    end else begin
      access_waiting_force_n_q <= !(pending && !grant_s);
      if (ctrl_q[BIT_GRANT_SEL]) begin
        dual_q <= !(ctrl_q[BIT_FORCE] || pending);
      end else begin
        dual_q <= !strobe;
      end
    end
  end

  // wide port mode takes the flag pins away from this word
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flag_o_q <= '0;
      flag_oe_q <= '0;
    end else begin
      flag_o_q <= flag_out_q;
      flag_oe_q <= {{4{ctrl_q[BIT_HIGH_DIR] && !wide_q}},
                    {4{ctrl_q[BIT_LOW_DIR] && !wide_q}}};
    end
  end

  assign ADDRESS_BUS_PINS_O = addr_o_q;
  assign ADDRESS_BUS_PINS_OE = addr_oe_q;
  assign DATA_BUS_PINS_O = data_o_q;
  assign DATA_BUS_PINS_OE = data_oe_q;
  assign BYTE_LANE_SELECT_N_O = lane_n_q;
  assign BYTE_LANE_SELECT_N_OE = lane_oe_q;
  assign DUAL_PIN_O = dual_q;
  assign DUAL_PIN_OE = 1'b1;
  assign PENDING_NO_GRANT_N = access_waiting_force_n_q;
  assign HOST_PORT_FLAG_PINS_O = flag_o_q;
  assign HOST_PORT_FLAG_PINS_OE = flag_oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_oe_mode;
    @(posedge REF_CLK) disable iff (!RESET_N)
    !ctrl_q[BIT_GRANT_SEL] |=> DUAL_PIN_O == !$past(strobe);
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("dual pin does not follow output enable");

  property p_force_low;
    @(posedge REF_CLK) disable iff (!RESET_N)
    ctrl_q[BIT_GRANT_SEL] && ctrl_q[BIT_FORCE] |=> !DUAL_PIN_O;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("forced pending did not pull dual pin low");

  property p_access_waiting_force_mode;
    @(posedge REF_CLK) disable iff (!RESET_N)
    ctrl_q[BIT_GRANT_SEL] && !ctrl_q[BIT_FORCE] |=>
      DUAL_PIN_O == !$past(pending);
  endproperty
  a_access_waiting_force_mode: assert property (p_access_waiting_force_mode)
    else $error("dual pin does not show pending access");

  property p_no_grant;
    @(posedge REF_CLK) disable iff (!RESET_N)
    pending && !grant_s |=> !PENDING_NO_GRANT_N;
  endproperty
  a_no_grant: assert property (p_no_grant)
    else $error("pending without grant not signalled");

  property p_flag_dir;
    @(posedge REF_CLK) disable iff (!RESET_N)
    ctrl_q[BIT_LOW_DIR] && !ctrl_q[BIT_HIGH_DIR] && !wide_q |=>
      HOST_PORT_FLAG_PINS_OE == 8'h0f;
  endproperty
  a_flag_dir: assert property (p_flag_dir)
    else $error("low flag nibble direction wrong");

  property p_wide_in;
    @(posedge REF_CLK) disable iff (!RESET_N)
    wide_q |=> HOST_PORT_FLAG_PINS_OE == 8'h00;
  endproperty
  a_wide_in: assert property (p_wide_in)
    else $error("flag pins driven in wide port mode");

  property p_addr_drive;
    @(posedge REF_CLK) disable iff (!RESET_N)
    $rose(ADDRESS_BUS_PINS_OE) |-> $past(state_q) == S_ACC &&
      !BYTE_LANE_SELECT_N_OE == 1'b0;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("address bus driven outside an access");

  property p_data_dir;
    @(posedge REF_CLK) disable iff (!RESET_N)
    DATA_BUS_PINS_OE |-> ADDRESS_BUS_PINS_OE && $past(acc_wr_q);
  endproperty
  a_data_dir: assert property (p_data_dir)
    else $error("data bus driven during a read");

  c_write: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    $rose(DATA_BUS_PINS_OE));
  c_read: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    state_q == S_HOLD && hold_q == 2'h0 && !acc_wr_q);
  c_wait_grant: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    pending && !grant_s [*3]);
endmodule : emc_ctrl

// ==== rtl/emc_pkg.sv ====
package emc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int FLAG_W = 8;
  localparam int CW_W = 16;
  localparam int SYNC_STAGES = 2;

  typedef logic [ADDR_W-1:0] emc_addr_type;
  typedef logic [DATA_W-1:0] emc_data_type;
  typedef logic [LANE_W-1:0] emc_lane_type;
  typedef logic [FLAG_W-1:0] emc_flag_type;
  typedef logic [CW_W-1:0] emc_cw_type;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_WORD = 8'h00;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h04;
  localparam logic [7:0] OFS_FLAG_OUT = 8'h08;
  localparam logic [7:0] OFS_FLAG_IN = 8'h0c;
  localparam logic [7:0] OFS_ACC_ADDR = 8'h10;
  localparam logic [7:0] OFS_ACC_WDATA = 8'h14;
  localparam logic [7:0] OFS_ACC_CMD = 8'h18;
  localparam logic [7:0] OFS_ACC_RDATA = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_B_EN = 0;
  localparam int BIT_A_EN = 1;
  localparam int FLD_B_CNT = 2;
  localparam int FLD_A_CNT = 4;
  localparam int BIT_LOW_DIR = 6;
  localparam int BIT_HIGH_DIR = 7;
  localparam int BIT_GRANT_SEL = 8;
  localparam int BIT_FORCE = 9;
  localparam emc_cw_type CW_USED_MASK = 16'h03ff;
  localparam int BIT_WIDE_PORT = 0;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_LANES = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACCESS_WAITING_FORCE = 1;
  localparam int PART_B_BIT = 21;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam emc_cw_type CTRL_WORD_RST = 16'h0000;
  localparam logic PORT_CTRL_RST = 1'b0;
  localparam emc_flag_type FLAG_OUT_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: one wait state is one period of the input clock
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real WAIT_STATE_NS_AT_FMAX = 12.5;
  localparam real WAIT_STATE_NS = CLK_PERIOD_NS;
  localparam int WAIT_STATE_CYC = int'(WAIT_STATE_NS / CLK_PERIOD_NS);
  localparam logic [1:0] CODE_READY = 2'b11;

  // wait states for a count code; the ready code gives its minimum
  function automatic logic [1:0] wait_count(input logic [1:0] code);
    logic [1:0] n;
    n = 2'h2;
    if (code != CODE_READY) begin
      n = code + 2'h1;
    end
    return n;
  endfunction : wait_count

endpackage : emc_pkg

// ==== rtl/emc_sync.sv ====
`timescale 1ns/10ps
module emc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : emc_sync

// ==== rtl/emc_wait_if.sv ====
`timescale 1ns/10ps
interface emc_wait_if;
  logic start;
  logic enable;
  logic [1:0] code;
  logic done;
  logic busy;

  modport ctrl (output start, output enable, output code,
                input done, input busy);
  modport gen (input start, input enable, input code,
               output done, output busy);
endinterface : emc_wait_if

// ==== rtl/emc_waitgen.sv ====
`timescale 1ns/10ps
module emc_waitgen (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic ready_low_s, // synchronised ready, low = ready
  emc_wait_if.gen w // control from the access sequencer
);
  import emc_pkg::*;

  logic [1:0] cnt_q;
  logic busy_q;
  logic rdy_mode_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      rdy_mode_q <= 1'b0;
    end else if (w.start) begin
      busy_q <= 1'b1;
      cnt_q <= w.enable ? wait_count(w.code) : 2'h0;
      rdy_mode_q <= w.enable && (w.code == CODE_READY);
    end else if (w.done) begin
      busy_q <= 1'b0;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // after the minimum count the ready code keeps stretching
  assign w.done = busy_q && (cnt_q == 2'h0) &&
                  (!rdy_mode_q || !ready_low_s);
  assign w.busy = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_three_waits;
    @(posedge clk) disable iff (!rst_n)
    w.start && w.enable && w.code == 2'b10 |-> ##1 !w.done [*3] ##1 w.done;
  endproperty
  a_three_waits: assert property (p_three_waits)
    else $error("three wait states not honoured");

  property p_one_wait;
    @(posedge clk) disable iff (!rst_n)
    w.start && w.enable && w.code == 2'b00 |-> ##1 !w.done ##1 w.done;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("one wait state not honoured");

  property p_ready_min;
    @(posedge clk) disable iff (!rst_n)
    w.start && w.enable && w.code == CODE_READY |-> ##1 !w.done [*2];
  endproperty
  a_ready_min: assert property (p_ready_min)
    else $error("ready mode ended before two wait states");

  property p_gen_off;
    @(posedge clk) disable iff (!rst_n)
    w.start && !w.enable |-> ##1 w.done;
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("disabled generator still inserted wait states");

  c_ready_wait: cover property (@(posedge clk) disable iff (!rst_n)
    rdy_mode_q && busy_q && cnt_q == 2'h0 && ready_low_s);
endmodule : emc_waitgen

// ==== verification/emc_ctrl_tb.sv ====
`timescale 1ns/10ps
// ----
// bench top
// ----
module emc_ctrl_tb;
  import emc_pkg::*;
  logic REF_CLK, RESET_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic BUS_GRANT, EXT_READY_LOW, ADDRESS_BUS_PINS_OE, DATA_BUS_PINS_OE;
  logic BYTE_LANE_SELECT_N_OE, DUAL_PIN_O, DUAL_PIN_OE, PENDING_NO_GRANT_N;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [7:0] rdly;
  emc_addr_type ADDRESS_BUS_PINS_O, addr_seen;
  emc_data_type DATA_BUS_PINS_I, DATA_BUS_PINS_O;
  emc_lane_type BYTE_LANE_SELECT_N_O, lane_seen;
  emc_flag_type HOST_PORT_FLAG_PINS_I, HOST_PORT_FLAG_PINS_O;
  emc_flag_type HOST_PORT_FLAG_PINS_OE, oe;
  int err_count, tests_run, run, dur;
  assign HREADY = HREADYOUT;
  // undriven flag pins float to a fixed pattern from outside
  assign HOST_PORT_FLAG_PINS_I = (HOST_PORT_FLAG_PINS_O &
    HOST_PORT_FLAG_PINS_OE) | (8'h5a & ~HOST_PORT_FLAG_PINS_OE);
  emc_ctrl i_dut (.REF_CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HREADYOUT, .HRDATA, .HRESP, .BUS_GRANT,
    .EXT_READY_LOW, .ADDRESS_BUS_PINS_O, .ADDRESS_BUS_PINS_OE,
    .DATA_BUS_PINS_I, .DATA_BUS_PINS_O, .DATA_BUS_PINS_OE,
    .BYTE_LANE_SELECT_N_O, .BYTE_LANE_SELECT_N_OE, .DUAL_PIN_O,
    .DUAL_PIN_OE, .PENDING_NO_GRANT_N, .HOST_PORT_FLAG_PINS_I,
    .HOST_PORT_FLAG_PINS_O, .HOST_PORT_FLAG_PINS_OE);
  emc_mem_model i_mem (.clk(REF_CLK), .addr(ADDRESS_BUS_PINS_O),
    .lanes_n(BYTE_LANE_SELECT_N_O), .dq_o(DATA_BUS_PINS_O),
    .dq_oe(DATA_BUS_PINS_OE), .rdly(rdly), .dq(DATA_BUS_PINS_I),
    .rdy_n(EXT_READY_LOW));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // length of the last pin-driving window, with what it showed
  always @(posedge REF_CLK) begin
    if (ADDRESS_BUS_PINS_OE === 1'b1) begin
      run <= run + 1;
      addr_seen <= ADDRESS_BUS_PINS_O;
      lane_seen <= BYTE_LANE_SELECT_N_O;
    end else if (run != 0) begin
      dur <= run;
      run <= 0;
    end
  end
  task summarize();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rdy_wait();
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 20);
    if (HREADYOUT !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask : rdy_wait
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    rdy_wait();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rdy_wait();
    rd = HRDATA;
  endtask : ahb
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  // poll busy, then fetch the read data
  task acc_done();
    int n;
    n = 0;
    do begin
      ahb(1'b0, OFS_ACC_CMD, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 60);
    if (n >= 60) begin
      err_count++;
      summarize();
    end
    ahb(1'b0, OFS_ACC_RDATA, 32'h0);
  endtask : acc_done
  task acc(input logic [31:0] a, input logic [31:0] d, input logic [5:0] c);
    ahb(1'b1, OFS_ACC_ADDR, a);
    ahb(1'b1, OFS_ACC_WDATA, d);
    ahb(1'b1, OFS_ACC_CMD, {26'h0, c});
    acc_done();
  endtask : acc
  task t_regs();
    rchk("ctrl word", OFS_CTRL_WORD, 32'h0);
    chk("lanes idle", 32'hf, BYTE_LANE_SELECT_N_O);
    chk("lanes oe idle", 32'h0, BYTE_LANE_SELECT_N_OE);
    chk("dual pin oe", 32'h1, DUAL_PIN_OE);
    chk("hresp", 32'h0, HRESP);
    ahb(1'b1, OFS_CTRL_WORD, 32'hffff);
    rchk("ctrl mask", OFS_CTRL_WORD, 32'h3ff);
    rchk("unmapped", 8'h20, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task t_flags();
    ahb(1'b1, OFS_FLAG_OUT, 32'h03);
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, OFS_PORT_CTRL, i / 4);
      ahb(1'b1, OFS_CTRL_WORD, (i % 4) << 6);
      repeat (4) @(posedge REF_CLK);
      oe = {{4{i[1]}}, {4{i[0]}}} & {8{!i[2]}};
      chk("flag oe", oe, HOST_PORT_FLAG_PINS_OE);
      rchk("flag in", OFS_FLAG_IN, (8'h03 & oe) | (8'h5a & ~oe));
    end
    ahb(1'b1, OFS_PORT_CTRL, 32'h0);
    $display("t_flags done");
  endtask : t_flags
  task t_dual();
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, OFS_CTRL_WORD, i << 8);
      repeat (2) @(posedge REF_CLK);
      chk("dual pin", i != 3, DUAL_PIN_O);
    end
    BUS_GRANT <= 1'b0;
    ahb(1'b1, OFS_CTRL_WORD, 32'h100);
    ahb(1'b1, OFS_ACC_CMD, 32'h3d);
    repeat (4) @(posedge REF_CLK);
    chk("access_waiting_force no grant", 32'h0, PENDING_NO_GRANT_N);
    chk("dual pending", 32'h0, DUAL_PIN_O);
    BUS_GRANT <= 1'b1;
    acc_done();
    chk("access_waiting_force released", 32'h1, PENDING_NO_GRANT_N);
    $display("t_dual done");
  endtask : t_dual
  task t_waits();
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, OFS_CTRL_WORD,
          ((i % 2) ? 1 : 2) | ((i / 2) << (4 - 2 * (i % 2))));
      acc((i % 2) << 21, 32'h0, 6'h3d);
      chk("wait count", 5 + i / 2, dur);
    end
    ahb(1'b1, OFS_CTRL_WORD, 32'h21);
    acc(32'h0, 32'h0, 6'h3d);
    chk("a gen off", 32'h4, dur);
    ahb(1'b1, OFS_CTRL_WORD, 32'h0a);
    acc(32'h200000, 32'h0, 6'h3d);
    chk("b gen off", 32'h4, dur);
    ahb(1'b1, OFS_CTRL_WORD, 32'h32);
    acc(32'h0, 32'h0, 6'h3d);
    // ready crosses two flops, so a fast memory still costs three waits
    chk("ready fast", 32'h7, dur);
    rdly <= 8'd10;
    acc(32'h0, 32'h0, 6'h3d);
    chk("ready slow", 32'd17, dur);
    rdly <= 8'd0;
    $display("t_waits done");
  endtask : t_waits
  task t_data();
    ahb(1'b1, OFS_CTRL_WORD, 32'h0);
    acc(32'h3ffff4, 32'h11223344, 6'h17);
    chk("lanes", 32'ha, lane_seen);
    chk("address", 32'h3ffff4, addr_seen);
    acc(32'h3ffff4, 32'h0, 6'h3d);
    chk("read data", 32'h00220044, rd);
    $display("t_data done");
  endtask : t_data
  initial begin
    RESET_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'b010;
    HWDATA = 32'h0;
    BUS_GRANT = 1'b1;
    rdly = 8'd0;
    err_count = 0;
    tests_run = 0;
    run = 0;
    dur = 0;
    repeat (6) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    t_regs();
    t_flags();
    t_dual();
    t_waits();
    t_data();
    summarize();
  end
endmodule : emc_ctrl_tb

// ==== verification/emc_mem_model.sv ====
`timescale 1ns/10ps
// ----
// external memory with slow ready
// ----
module emc_mem_model (
  input wire logic clk, // clock
  input wire logic [21:0] addr, // address pins
  input wire logic [3:0] lanes_n, // lane selects, low
  input wire logic [31:0] dq_o, // data from device
  input wire logic dq_oe, // device drives data
  input wire logic [7:0] rdly, // cycles before ready
  output logic [31:0] dq, // resolved data bus
  output logic rdy_n // ready, low
);
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [7:0] age;
  logic sel;
  assign sel = (lanes_n != 4'hf);
  initial begin
    last = 32'h0;
    age = 8'h0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // released bus shows the inverse of its last value, not a stale match
  assign dq = dq_oe ? dq_o : (sel ? mem[addr[3:0]] : ~last);
  assign rdy_n = !(sel && age >= rdly);
  always @(posedge clk) begin
    age <= sel ? age + 8'h1 : 8'h0;
    if (sel) last <= dq;
    for (int i = 0; i < 4; i++) begin
      if (dq_oe && !lanes_n[i]) mem[addr[3:0]][i*8 +: 8] <= dq_o[i*8 +: 8];
    end
  end
endmodule : emc_mem_model
